// File: design/rvpg_pkg.sv
// Constants and types of the ramp and V/F profile generator
package rvpg_pkg;

    localparam int ADDR_W = 8;
    localparam int CLK_NS = 100;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TCNT_W = $clog2(TICK_CYC);
    localparam int UNIT0_NS = 10000000;
    localparam int UNIT1_NS = 100000000;
    localparam int UNIT2_NS = 1000000000;
    localparam logic [13:0] TPU0 = 14'(UNIT0_NS / TICK_NS);
    localparam logic [13:0] TPU1 = 14'(UNIT1_NS / TICK_NS);
    localparam logic [13:0] TPU2 = 14'(UNIT2_NS / TICK_NS);
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam int QF = 16;
    localparam int DIV_N = 48;
    localparam int DIV_D = 40;
    localparam logic [5:0] DIV_LAST = 6'h30;

    // Register byte offsets
    localparam logic [7:0] A_TERM = 8'h00;
    localparam logic [7:0] A_CFG = 8'h04;
    localparam logic [7:0] A_TGT = 8'h08;
    localparam logic [7:0] A_FREQ = 8'h0C;
    localparam logic [7:0] A_STRT = 8'h10;
    localparam logic [7:0] A_UF01 = 8'h14;
    localparam logic [7:0] A_UF23 = 8'h18;
    localparam logic [7:0] A_UV = 8'h1C;
    localparam logic [2:0] TBL_PAGE = 3'h1;
    localparam logic [7:0] A_STAT = 8'h40;
    localparam logic [7:0] A_VOLT = 8'h44;
    localparam logic [7:0] A_END = 8'h48;

    // Terminal function codes and terminal masks
    localparam logic [4:0] FN_W1 = 5'h08;
    localparam logic [4:0] FN_W2 = 5'h09;
    localparam logic [4:0] FN_W4 = 5'h0A;
    localparam logic [4:0] FN_HOLD = 5'h18;
    localparam logic [4:0] MASK_STD = 5'h07;
    localparam logic [4:0] MASK_ADV = 5'h1F;

    localparam logic [1:0] VF_LIN = 2'h0;
    localparam logic [1:0] VF_SQR = 2'h1;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef struct packed {
        logic [6:0] end_pct;
        logic [6:0] start_pct;
        logic adv_io;
        logic [1:0] vf_sel;
        logic [1:0] res;
        logic ref_sel;
        logic dn_shape;
        logic up_shape;
    } rvpg_cfg_t;

    typedef enum logic [1:0] {PH_STEP, PH_JS, PH_JE, PH_VOLT} rvpg_ph_t;

    // Reset values
    localparam logic [24:0] TERM_RST = {5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
    localparam rvpg_cfg_t CFG_RST = '{7'h28, 7'h28, 1'b1, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0};
    localparam logic [31:0] FREQ_RST = 32'h1770_1770;
    localparam logic [31:0] STRT_RST = 32'h0000_0032;
    localparam logic [31:0] UF01_RST = 32'h0BB8_05DC;
    localparam logic [31:0] UF23_RST = 32'h1770_1194;
    localparam logic [31:0] UV_RST = 32'h644B_3219;
    localparam logic [31:0] TBL_RST [8] = '{32'h0064_0032, 32'h0014_0014, 32'h001E_001E, 32'h0028_0028,
                                           32'h0032_0032, 32'h0028_0028, 32'h001E_001E, 32'h0014_0014};
endpackage

// File: design/rvpg_top.sv
// Ramp and V/F profile generator with AXI4-Lite register slave
//
// Contract
// - Function codes 8, 9, 10 give a terminal index bits 0, 1, 2.
// - Index is weighted sum 1/2/4; indexes 1-7 pick stored time pairs.
// - Index zero uses the primary ramp-up and ramp-down times.
// - Standard build has terminals zero to two; advanced build has five.
// - Separate up/down shape selects, 0 linear, 1 S-curve, both reset 0.
// - Linear shape moves frequency at constant rate toward target.
// - Start rounding 1-100 percent, default 40, shapes ramp departure.
// - End rounding 1-100 percent, default 40, shapes ramp arrival.
// - S-curve ramp-up lasts T times one plus half of both fractions.
// - S-curve ramp-down lasts T times one plus half of both fractions.
// - Below maximum frequency the upper rounding may be cut short.
// - Function code 24 held freezes output frequency in both directions.
// - Curve 0 gives voltage linear in frequency.
// - Base frequency, default 60.00 Hz, reaches rated voltage.
// - No output voltage below start frequency, default 0.50 Hz.
// - Curve 1 gives voltage proportional to frequency squared.
// - Curve 2 follows four user points, voltages in percent.
// - User curve applies no low-speed voltage boost.
// - Nonzero voltage setting is base voltage; above base clip to input.
// - Voltage setting zero derives output voltage from measured input.
// - Reference 0 spans zero to maximum; reference 1 spans the step.
// - Time resolution 0.01 s, 0.1 s or 1 s for settings 0, 1, 2.
`timescale 1ns/100ps
module rvpg_top
    import rvpg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rvpg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [rvpg_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [4:0] term_in,
    input wire logic [8:0] in_volt,
    output logic [15:0] out_freq,
    output logic [8:0] out_volt
);
    import rvpg_pkg::*;

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[8*i +: 8] = d[8*i +: 8];
        return r;
    endfunction

    // Any active terminal carrying a given function code
    function automatic logic f_hit(input logic [24:0] codes, input logic [4:0] act, input logic [4:0] code);
        logic h;
        h = 1'b0;
        for (int i = 0; i < 5; i++)
            h = h | (act[i] & (codes[5*i +: 5] == code));
        return h;
    endfunction

    // Divider quotient clipped to 32 bits
    function automatic logic [31:0] f_sat(input logic [DIV_N-1:0] q);
        return (|q[DIV_N-1:32]) ? 32'hFFFF_FFFF : q[31:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic awready_ff, wready_ff, aw_got_ff, w_got_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [24:0] term_ff;
    rvpg_cfg_t cfg_ff;
    logic [31:0] tgt_ff, frq_ff, strt_ff, uf01_ff, uf23_ff, uv_ff;
    logic [31:0] tbl_ff [8];
    logic [31:0] stat_w, rd_word;
    logic [8:0] volt_ff;

    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take = s_axi_wvalid & wready_ff;
    wire ar_take = s_axi_arvalid & arready_ff;
    wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire nxt_aw_got = (aw_got_ff | aw_take) & ~wr_fire;
    wire nxt_w_got = (w_got_ff | w_take) & ~wr_fire;
    wire nxt_fire = nxt_aw_got & nxt_w_got & ~(wr_fire | (bvalid_ff & ~s_axi_bready));
    wire wr_hit = waddr_ff < A_STAT;
    wire rd_hit = s_axi_araddr < A_END;
    wire [31:0] wm_word = f_merge(rd_word, wdata_ff, wstrb_ff);
    wire [ADDR_W-1:0] sel_addr = wr_fire ? waddr_ff : s_axi_araddr;
    wire sel_tbl = sel_addr[7:5] == TBL_PAGE;

    // Read selection, shared by read data and write merge
    assign rd_word = sel_tbl ? tbl_ff[sel_addr[4:2]] :
                     (sel_addr == A_TERM) ? {7'h00, term_ff} :
                     (sel_addr == A_CFG) ? {10'h000, cfg_ff} :
                     (sel_addr == A_TGT) ? tgt_ff :
                     (sel_addr == A_FREQ) ? frq_ff :
                     (sel_addr == A_STRT) ? strt_ff :
                     (sel_addr == A_UF01) ? uf01_ff :
                     (sel_addr == A_UF23) ? uf23_ff :
                     (sel_addr == A_UV) ? uv_ff :
                     (sel_addr == A_STAT) ? stat_w :
                     (sel_addr == A_VOLT) ? {23'h000000, volt_ff} : 32'h0000_0000;

    // Channel handshakes, address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OK;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OK;
        end
        else
        begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awready_ff <= ~nxt_aw_got;
            wready_ff <= ~nxt_w_got;
            if (wr_fire)
                bresp_ff <= wr_hit ? RESP_OK : RESP_ERR;
            bvalid_ff <= wr_fire | (bvalid_ff & ~s_axi_bready);
            arready_ff <= ~(ar_take | (rvalid_ff & ~s_axi_rready) | nxt_fire); // Selector busy with a write
            if (ar_take)
            begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_hit ? RESP_OK : RESP_ERR;
            end
            rvalid_ff <= ar_take | (rvalid_ff & ~s_axi_rready);
        end
    end

    // Captured address and data of the pending write
    always_ff @(posedge aclk)
    begin
        if (aw_take)
            waddr_ff <= s_axi_awaddr;
        if (w_take)
        begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    // Settings registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            term_ff <= TERM_RST;
            cfg_ff <= CFG_RST;
            tgt_ff <= 32'h0000_0000;
            frq_ff <= FREQ_RST;
            strt_ff <= STRT_RST;
            uf01_ff <= UF01_RST;
            uf23_ff <= UF23_RST;
            uv_ff <= UV_RST;
            tbl_ff <= TBL_RST;
        end
        else if (wr_fire && wr_hit)
        begin
            if (sel_tbl)
                tbl_ff[waddr_ff[4:2]] <= wm_word;
            if (waddr_ff == A_TERM)
                term_ff <= wm_word[24:0];
            if (waddr_ff == A_CFG)
                cfg_ff <= rvpg_cfg_t'(wm_word[$bits(rvpg_cfg_t)-1:0]);
            if (waddr_ff == A_TGT)
                tgt_ff <= wm_word;
            if (waddr_ff == A_FREQ)
                frq_ff <= wm_word;
            if (waddr_ff == A_STRT)
                strt_ff <= wm_word;
            if (waddr_ff == A_UF01)
                uf01_ff <= wm_word;
            if (waddr_ff == A_UF23)
                uf23_ff <= wm_word;
            if (waddr_ff == A_UV)
                uv_ff <= wm_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Terminal inputs and control tick
    logic [4:0] s1_ff, s2_ff, s3_ff, filt_ff;
    logic [TCNT_W-1:0] tcnt_ff;
    logic tick_ff, hold_ff;
    logic [2:0] idx_ff;

    wire [4:0] act = filt_ff & (cfg_ff.adv_io ? MASK_ADV : MASK_STD);
    wire [2:0] idx_now = {f_hit(term_ff, act, FN_W4), f_hit(term_ff, act, FN_W2), f_hit(term_ff, act, FN_W1)};
    wire hold_now = f_hit(term_ff, act, FN_HOLD);

    // Three-stage pin sampling, change taken when stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_ff <= 5'h00;
            s2_ff <= 5'h00;
            s3_ff <= 5'h00;
            filt_ff <= 5'h00;
            tcnt_ff <= '0;
            tick_ff <= 1'b0;
            idx_ff <= 3'h0;
            hold_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= term_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));
            tick_ff <= tcnt_ff == TCNT_W'(TICK_CYC - 1);
            tcnt_ff <= (tcnt_ff == TCNT_W'(TICK_CYC - 1)) ? '0 : tcnt_ff + 1'b1;
            if (tick_ff)
            begin
                idx_ff <= idx_now;
                hold_ff <= hold_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp rates
    logic [31:0] facc_ff, rate_ff, step_ff, js_ff, je_ff;
    logic [15:0] span_ff, tseen_ff;
    logic dir_ff;

    wire [15:0] fint = facc_ff[31:QF];
    wire [15:0] tgt_q = (tgt_ff[15:0] > frq_ff[15:0]) ? frq_ff[15:0] : tgt_ff[15:0];
    wire up = tgt_q > fint;
    wire [31:0] sel_pair = tbl_ff[idx_ff];
    wire [15:0] t_units = up ? sel_pair[15:0] : sel_pair[31:16];
    wire [13:0] tpu = (cfg_ff.res == 2'h0) ? TPU0 : (cfg_ff.res == 2'h1) ? TPU1 : TPU2;
    wire [31:0] t_ticks = {16'h0000, t_units} * {18'h00000, tpu};
    wire [15:0] span = cfg_ff.ref_sel ? span_ff : frq_ff[15:0];
    wire s_shape = up ? cfg_ff.up_shape : cfg_ff.dn_shape;

    ////////////////////////////////////////////////////////////////////////
    // Shared divider: full step, rounding slews, then voltage
    rvpg_ph_t ph_ff;
    logic [5:0] bit_ff;
    logic [DIV_N-1:0] num_ff, quo_ff;
    logic [DIV_D-1:0] den_ff;
    logic [DIV_D:0] rem_ff;
    logic [DIV_N-1:0] num_sel, v_num;
    logic [DIV_D-1:0] den_sel, v_den;
    logic [15:0] vf_ff;
    logic [8:0] v_out;

    wire [DIV_D:0] rtry = {rem_ff[DIV_D-1:0], num_ff[DIV_N-1]};
    wire ge = rtry >= {1'b0, den_ff};
    wire [31:0] qs = f_sat(quo_ff);
    wire [6:0] pct_sel = (ph_ff == PH_JS) ? cfg_ff.start_pct : cfg_ff.end_pct;

    // Operand selection per phase
    always_comb
    begin
        case (ph_ff)
            PH_STEP:
            begin
                num_sel = {16'h0000, span, 16'h0000};
                den_sel = {8'h00, t_ticks};
            end
            PH_JS, PH_JE:
            begin
                num_sel = 48'({16'h0000, step_ff} * 48'(PCT_FULL));
                den_sel = 40'({33'h0, pct_sel} * {8'h00, t_ticks});
            end
            default:
            begin
                num_sel = v_num;
                den_sel = v_den;
            end
        endcase
    end

    // Restoring division, one quotient bit per cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_ff <= PH_STEP;
            bit_ff <= 6'h00;
            step_ff <= 32'h0000_0000;
            js_ff <= 32'h0000_0000;
            je_ff <= 32'h0000_0000;
            volt_ff <= 9'h000;
            vf_ff <= 16'h0000;
        end
        else if (bit_ff == 6'h00)
        begin
            num_ff <= num_sel;
            den_ff <= den_sel;
            rem_ff <= '0;
            quo_ff <= '0;
            bit_ff <= 6'h01;
            // Keep the quotient of the phase just finished
            case (ph_ff)
                PH_JS:
                    step_ff <= qs;
                PH_JE:
                    js_ff <= qs;
                PH_VOLT:
                begin
                    je_ff <= qs;
                    vf_ff <= fint;
                end
                default:
                    volt_ff <= v_out;
            endcase
        end
        else
        begin
            num_ff <= {num_ff[DIV_N-2:0], 1'b0};
            rem_ff <= ge ? rtry - {1'b0, den_ff} : rtry;
            quo_ff <= {quo_ff[DIV_N-2:0], ge};
            bit_ff <= (bit_ff == DIV_LAST) ? 6'h00 : bit_ff + 6'h01;
            if (bit_ff == DIV_LAST)
                case (ph_ff)
                    PH_STEP:
                        ph_ff <= PH_JS;
                    PH_JS:
                        ph_ff <= PH_JE;
                    PH_JE:
                        ph_ff <= PH_VOLT;
                    default:
                        ph_ff <= PH_STEP;
                endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Voltage curve operands and limits
    logic [15:0] fa, fb;
    logic [6:0] pa, pb;

    wire [8:0] vr = (strt_ff[24:16] == 9'h000) ? in_volt : strt_ff[24:16];
    wire [15:0] fbase = frq_ff[31:16];
    wire [15:0] uf [4] = '{uf01_ff[15:0], uf01_ff[31:16], uf23_ff[15:0], uf23_ff[31:16]};
    wire [6:0] up_ [4] = '{uv_ff[6:0], uv_ff[14:8], uv_ff[22:16], uv_ff[30:24]};
    wire beyond = vf_ff >= uf[3];

    // User curve segment around the latched frequency
    always_comb
    begin
        fa = 16'h0000;
        pa = 7'h00;
        fb = uf[0];
        pb = up_[0];
        for (int i = 1; i < 4; i++)
            if (vf_ff >= uf[i-1])
            begin
                fa = uf[i-1];
                pa = up_[i-1];
                fb = uf[i];
                pb = up_[i];
            end
    end

    // Numerator and divisor of the voltage quotient
    always_comb
    begin
        if (cfg_ff.vf_sel == VF_LIN)
        begin
            v_num = 48'({39'h0, vr} * {32'h0, vf_ff});
            v_den = {24'h000000, fbase};
        end
        else if (cfg_ff.vf_sel == VF_SQR)
        begin
            v_num = 48'({39'h0, vr} * {32'h0, vf_ff} * {32'h0, vf_ff});
            v_den = 40'({24'h000000, fbase} * {24'h000000, fbase});
        end
        else if (beyond)
        begin
            v_num = 48'({41'h0, pb} * {39'h0, vr});
            v_den = {33'h0, PCT_FULL};
        end
        else
        begin
            // Boost terms never enter this path
            v_num = 48'(({41'h0, pa} * 48'(fb - vf_ff) + {41'h0, pb} * 48'(vf_ff - fa)) * {39'h0, vr});
            v_den = 40'({24'h000000, fb - fa} * {33'h0, PCT_FULL});
        end
        if (vf_ff < strt_ff[15:0])
            v_out = 9'h000;
        else if (qs > {23'h0, vr})
            v_out = vr;
        else
            v_out = qs[8:0];
        if (vf_ff > fbase && in_volt < v_out)
            v_out = in_volt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp engine, one update per tick
    wire [31:0] t_q = {tgt_q, 16'h0000};
    wire [31:0] remn = up ? t_q - facc_ff : facc_ff - t_q;
    wire [31:0] r0 = (up != dir_ff) ? 32'h0000_0000 : rate_ff;
    wire [63:0] p_rj = {32'h0, remn} * {32'h0, je_ff};
    wire [63:0] p_rr = {32'h0, r0} * {32'h0, r0};
    wire brake = {p_rj, 1'b0} <= {1'b0, p_rr};
    wire [32:0] r_inc = {1'b0, r0} + {1'b0, js_ff};
    wire [31:0] r_acc = (r_inc > {1'b0, step_ff}) ? step_ff : r_inc[31:0];
    wire [31:0] r_dec = (r0 > je_ff) ? r0 - je_ff : 32'h0000_0001;
    wire [31:0] r_s = brake ? r_dec : r_acc;
    wire [31:0] r_new = !s_shape ? step_ff : (r_s == 32'h0) ? 32'h0000_0001 : r_s;
    wire land = remn <= r_new;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            facc_ff <= 32'h0000_0000;
            rate_ff <= 32'h0000_0000;
            dir_ff <= 1'b1;
            span_ff <= 16'h0000;
            tseen_ff <= 16'h0000;
        end
        else
        begin
            if (tgt_q != tseen_ff)
            begin
                tseen_ff <= tgt_q;
                span_ff <= up ? tgt_q - fint : fint - tgt_q;
            end
            if (tick_ff && !hold_ff && remn != 32'h0)
            begin
                dir_ff <= up;
                rate_ff <= land ? 32'h0000_0000 : r_new;
                facc_ff <= land ? t_q : up ? facc_ff + r_new : facc_ff - r_new;
            end
        end
    end

    assign stat_w = {11'h000, remn == 32'h0, hold_ff, idx_ff, fint};
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign out_freq = facc_ff[31:QF];
    assign out_volt = volt_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_hold;
        tick_ff && hold_ff |=> $stable(facc_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("frequency moved under hold");

    property p_land;
        tick_ff && !hold_ff && up |=> facc_ff <= $past(t_q);
    endproperty
    a_land: assert property (p_land) else $error("frequency overshot target");

    property p_idx;
        tick_ff |=> idx_ff == $past(idx_now);
    endproperty
    a_idx: assert property (p_idx) else $error("ramp index not taken at tick");

    property p_std;
        !cfg_ff.adv_io |-> (act & ~MASK_STD) == 5'h00;
    endproperty
    a_std: assert property (p_std) else $error("upper terminal used on standard build");

    property p_lin;
        tick_ff && !hold_ff && !s_shape && up && !land |=> facc_ff == $past(facc_ff) + $past(step_ff);
    endproperty
    a_lin: assert property (p_lin) else $error("linear step wrong");

    property p_start;
        ph_ff == PH_STEP && bit_ff == 6'h00 && vf_ff < strt_ff[15:0] |=> volt_ff == 9'h000;
    endproperty
    a_start: assert property (p_start) else $error("voltage below start frequency");

    property p_vmax;
        ph_ff == PH_STEP && bit_ff == 6'h00 |=> volt_ff <= $past(vr);
    endproperty
    a_vmax: assert property (p_vmax) else $error("voltage above rated value");

    property p_bhold;
        bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");

    c_hold: cover property (tick_ff && hold_ff && remn != 32'h0);
    c_scurve: cover property (tick_ff && s_shape && brake && !land);
    c_land: cover property (tick_ff && land && !hold_ff);
    c_user: cover property (cfg_ff.vf_sel == 2'h2 && volt_ff != 9'h000);
endmodule

// File: testbench/rvpg_far_side.sv
// Terminal contacts and mains supply seen by the generator
`timescale 1ns/100ps
module rvpg_far_side
(
    input wire logic aclk,
    input wire logic [4:0] pins,
    input wire logic [8:0] mains,
    output logic [4:0] term_in,
    output logic [8:0] in_volt
);
    // Contacts and supply settle one clock after the bench moves them
    always_ff @(posedge aclk)
    begin
        term_in <= pins;
        in_volt <= mains;
    end
endmodule

// File: testbench/rvpg_top_tb.sv
// Register-level bench for the ramp and V/F profile generator
`timescale 1ns/100ps
module rvpg_top_tb;
    import rvpg_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [4:0] pins = '0, term_in;
    logic [8:0] mains = 9'h0F0, in_volt, out_volt;
    logic [15:0] out_freq, f0;
    int miscompares = 0, total_checks = 0;
    ////////////////////////////////////////////////////////////////////////
    always #50 aclk = ~aclk;
    rvpg_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .term_in(term_in), .in_volt(in_volt), .out_freq(out_freq), .out_volt(out_volt));
    rvpg_far_side far (.aclk(aclk), .pins(pins), .mains(mains), .term_in(term_in), .in_volt(in_volt));
    ////////////////////////////////////////////////////////////////////////
    // Comparison of any result
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    // Register write, each channel released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge aclk);
        ta = 1'h0;
        tw = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) ta = 1'h1;
            if (s_axi_wready === 1'h1) tw = 1'h1;
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        rsp = s_axi_bresp;
    endtask
    // Register read
    task rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    // Read and compare in one step
    task rchk(input logic [7:0] a, input string n, input logic [31:0] e);
        rdr(a);
        chk(n, e, rd);
    endtask
    // Wait whole control ticks
    task tk(input int n);
        repeat (n * 1000) @(posedge aclk);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial
    begin
        repeat (90000) @(posedge aclk);
        miscompares++;
        conclude();
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rchk(A_CFG, "cfg", 32'h0014_2888);
        rchk(A_FREQ, "freq", 32'h1770_1770);
        rchk(A_STRT, "start", 32'h0000_0032);
        rchk(A_UF01, "uf01", 32'h0BB8_05DC);
        rchk(A_UV, "upct", 32'h644B_3219);
        rdr(A_END);
        chk("rresp", 32'h2, rsp);
        wr(A_STAT, 32'h0);
        chk("bresp", 32'h2, rsp);
        // Linear ramp on primary times, 0.01 s units
        wr(8'h20, 32'h0001_0001);
        wr(A_CFG, 32'h0014_2880);
        wr(A_TGT, 32'h0000_012C);
        repeat (3000) if (out_freq === 16'h0) @(posedge aclk);
        f0 = out_freq;
        tk(1);
        chk("step", 32'h3C, out_freq - f0);
        tk(6);
        chk("land", 32'h12C, out_freq);
        chk("volt in", 32'hC, out_volt);
        wr(A_STRT, 32'h00C8_0032);
        tk(1);
        chk("volt set", 32'hA, out_volt);
        // Hold on terminal 0, selectors on 1..3
        wr(A_TERM, 32'h0005_2518);
        pins <= 5'h01;
        tk(2);
        wr(A_TGT, 32'h0000_0258);
        tk(3);
        chk("hold", 32'h12C, out_freq);
        pins <= 5'h00;
        tk(8);
        chk("free", 32'h258, out_freq);
        // Index 7 with zero time jumps
        wr(8'h3C, 32'h0);
        pins <= 5'h0E;
        tk(2);
        rdr(A_STAT);
        chk("index", 32'h7, rd[18:16]);
        wr(A_TGT, 32'h0000_04B0);
        tk(3);
        chk("jump", 32'h4B0, out_freq);
        chk("lin volt", 32'h28, out_volt);
        wr(A_CFG, 32'h0014_28A0);
        tk(1);
        chk("sq volt", 32'h8, out_volt);
        wr(A_UV, 32'h644B_3232);
        wr(A_CFG, 32'h0014_2840);
        tk(2);
        rdr(A_STAT);
        chk("std index", 32'h3, rd[18:16]);
        chk("user volt", 32'h50, out_volt);
        // S-curve rise on primary times from the landed frequency
        pins <= 5'h00;
        wr(A_CFG, 32'h0014_2881);
        tk(2);
        f0 = out_freq;
        wr(A_TGT, 32'h0000_05DC);
        tk(2);
        chk("s start", 32'h1, out_freq - f0 < 16'h0078);
        tk(3);
        chk("s stretch", 32'h1, out_freq < 16'h05DC);
        tk(26);
        chk("s land", 32'h5DC, out_freq);
        conclude();
    end
endmodule
